/* hdl/pqt_pkg.sv */
// What this block does
// - pattern is the AND of chosen states over four channels and the external input
// - an input state is high above its threshold, low below it
// - each term is high, low or don't-care; don't-care never affects the result
// - any single mismatching non-don't-care term makes the pattern absent
// - trigger point selectable as entering or exiting the pattern
// - time hold-off from 10 ns to 20 s, 2 ns floor on the fast variant
// - event hold-off from 1 to 99 999 999 events
// - each input's threshold level is programmed independently
// - in qualified mode the validation only enables a separate trigger source
// - state-qualified needs the qualifier held continuously until the trigger
// - edge-qualified is armed by the validation alone
// - qualified trigger fires at once, after a time or event wait, or only within a window after validation
// - the wait timer or event counter restarts on every validation
// - qualifier selectable as pattern present or pattern absent
// - pattern only gates; source event while qualifier holds emits the trigger
// - source input may not be a pattern term; such setups are refused
// - state-qualified time wait restarts at qualifier start, fires after expiry
// - wait timeout runs while the qualifier holds in state mode and while armed in edge mode, and stops otherwise
package pqt_pkg;

  localparam int unsigned PQT_NUM_IN = 5;
  localparam int unsigned PQT_EXT_IDX = 4;

  // register byte offsets
  localparam logic [7:0] PQT_CTRL_OFS = 8'h00;
  localparam logic [7:0] PQT_PAT_OFS = 8'h04;
  localparam logic [7:0] PQT_HOLDOFF_OFS = 8'h08;
  localparam logic [7:0] PQT_WAIT_OFS = 8'h0C;
  localparam logic [7:0] PQT_STATUS_OFS = 8'h10;
  localparam logic [7:0] PQT_TRIGCNT_OFS = 8'h14;
  localparam logic [7:0] PQT_THRESH0_OFS = 8'h18;

  // status bit positions
  localparam int unsigned PQT_ST_REJ_BIT = 0;
  localparam int unsigned PQT_ST_PAT_BIT = 1;
  localparam int unsigned PQT_ST_HOLD_BIT = 2;
  localparam int unsigned PQT_ST_IN_LSB = 4;

  // pattern term codes, two bits per input
  localparam logic [1:0] PQT_TERM_X = 2'h0;
  localparam logic [1:0] PQT_TERM_HIGH = 2'h1;
  localparam logic [1:0] PQT_TERM_LOW = 2'h2;

  // reset values
  localparam logic [15:0] PQT_THRESH_RST = 16'h8000;
  localparam logic [31:0] PQT_HOLDOFF_RST = 32'h0000_0001;
  localparam logic [31:0] PQT_WAIT_RST = 32'h0000_0001;

  // timing, clock 125 MHz
  localparam longint unsigned PQT_CLK_HZ = 125_000_000;
  localparam longint unsigned PQT_CLK_PS = 8000;
  localparam longint unsigned PQT_TMIN_NS = 10;
  localparam longint unsigned PQT_TMIN_FAST_NS = 2;
  localparam longint unsigned PQT_TMAX_S = 20;
  localparam logic [31:0] PQT_TMIN_CYC =
    32'((PQT_TMIN_NS * 1000 + PQT_CLK_PS - 1) / PQT_CLK_PS);
  localparam logic [31:0] PQT_TMIN_FAST_CYC =
    32'((PQT_TMIN_FAST_NS * 1000 + PQT_CLK_PS - 1) / PQT_CLK_PS);
  localparam logic [31:0] PQT_TMAX_CYC = 32'(PQT_TMAX_S * PQT_CLK_HZ);
  localparam logic [31:0] PQT_EVT_MIN = 32'h0000_0001;
  localparam logic [31:0] PQT_EVT_MAX = 32'(99_999_999);

  typedef enum logic [1:0] {
    PQT_MODE_PATTERN,
    PQT_MODE_STATE_QUAL,
    PQT_MODE_EDGE_QUAL,
    PQT_MODE_OFF
  } pqt_mode_t;

  typedef enum logic [1:0] {
    PQT_HO_NONE,
    PQT_HO_TIME,
    PQT_HO_EVENTS,
    PQT_HO_RSVD
  } pqt_ho_t;

  typedef enum logic [1:0] {
    PQT_WT_NONE,
    PQT_WT_TIME,
    PQT_WT_EVENTS,
    PQT_WT_WINDOW
  } pqt_wait_t;

  // control register layout, msb first, bit 0 is enable
  typedef struct packed {
    logic src_fall;
    logic [2:0] src_sel;
    pqt_wait_t wait_kind;
    logic qual_absent;
    pqt_ho_t ho_kind;
    logic slope_exit;
    pqt_mode_t mode;
    logic enable;
  } pqt_ctrl_t;

  localparam int unsigned PQT_CTRL_W = $bits(pqt_ctrl_t);
  localparam pqt_ctrl_t PQT_CTRL_RST = '0;

  typedef logic [PQT_NUM_IN-1:0][15:0] pqt_thresh_t;

  // classic wishbone request and answer
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pqt_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } pqt_wb_rsp_t;

  // all state of the trigger block
  typedef struct packed {
    pqt_ctrl_t ctrl;
    logic [2*PQT_NUM_IN-1:0] pat;
    logic [31:0] holdoff;
    logic [31:0] waitv;
    pqt_thresh_t thresh;
    logic [PQT_NUM_IN-1:0] sync1;
    logic [PQT_NUM_IN-1:0] sync2;
    logic pat_prev;
    logic q_prev;
    logic src_prev;
    logic armed;
    logic [31:0] ho_cnt;
    logic [31:0] wcnt;
    logic rej_err;
    logic trig;
    logic [31:0] trig_cnt;
    logic ack;
    logic [31:0] rdat;
  } pqt_state_t;

endpackage : pqt_pkg

/* hdl/pqt_trigger.sv */
// Register access over Wishbone and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module pqt_trigger #(
  parameter logic FAST_VARIANT = 1'b0,
  parameter logic [31:0] TMAX_CYC = pqt_pkg::PQT_TMAX_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire pqt_pkg::pqt_wb_req_t wb_req_i,
  output pqt_pkg::pqt_wb_rsp_t wb_rsp_o,
  // comparator outputs, channels 0..3 then external_trigger_input
  input wire logic [pqt_pkg::PQT_NUM_IN-1:0] cmp_i,
  // threshold levels for the comparators
  output pqt_pkg::pqt_thresh_t thresh_level_o,
  // trigger event
  output logic trig_o
);
  import pqt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state and helpers

  pqt_state_t r;
  pqt_state_t n;
  logic [PQT_NUM_IN-1:0] match;
  logic pat_now;

  // merge write data into a register honouring byte lanes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // limit a programmed figure to its legal range
  function automatic logic [31:0] clamp(input logic [31:0] v,
                                        input logic [31:0] lo,
                                        input logic [31:0] hi);
    logic [31:0] res;
    res = v;
    if (v < lo) begin
      res = lo;
    end else if (v > hi) begin
      res = hi;
    end
    return res;
  endfunction : clamp

  // true when a qualified mode uses the source as a pattern term
  function automatic logic src_in_pattern(input pqt_ctrl_t c,
                                          input logic [2*PQT_NUM_IN-1:0] p);
    logic res;
    logic [3:0] idx;
    res = 1'b0;
    idx = {1'b0, c.src_sel};
    if ((c.mode == PQT_MODE_STATE_QUAL) || (c.mode == PQT_MODE_EDGE_QUAL)) begin
      if (idx >= 4'(PQT_NUM_IN)) begin
        res = 1'b1; // no such source, refuse as well
      end else if ((p[2*idx +: 2] == PQT_TERM_HIGH) || (p[2*idx +: 2] == PQT_TERM_LOW)) begin
        res = 1'b1;
      end
    end
    return res;
  endfunction : src_in_pattern

  ////////////////////////////////////////////////////////////////////////////
  // per input term match, evaluated on the synchronised state

  generate
    for (genvar i = 0; i < PQT_NUM_IN; i++) begin : g_term
      // high above threshold, low below; don't-care always matches
      always_comb begin
        case (r.pat[2*i +: 2])
          PQT_TERM_HIGH: match[i] = r.sync2[i];
          PQT_TERM_LOW: match[i] = ~r.sync2[i];
          default: match[i] = 1'b1;
        endcase
      end
    end
  endgenerate

  // one failing term kills the pattern
  assign pat_now = &match;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic acc;
    logic wr;
    logic [31:0] wd;
    pqt_ctrl_t c_cand;
    logic [2*PQT_NUM_IN-1:0] p_cand;
    logic cfg_wr;
    logic [31:0] tmin;
    logic [31:0] ho_time;
    logic [31:0] ho_evt;
    logic [31:0] wt_time;
    logic [31:0] wt_evt;
    logic cand;
    logic fire_pat;
    logic q;
    logic val;
    logic src;
    logic src_evt;
    logic hold;
    logic [31:0] wload;
    logic [31:0] wcur;
    logic ok;
    logic qual_mode;
    logic fire_q;
    logic fire;
    logic [2:0] s;
    acc = 1'b0;
    wr = 1'b0;
    wd = 32'h0000_0000;
    c_cand = r.ctrl;
    p_cand = r.pat;
    cfg_wr = 1'b0;
    tmin = 32'h0000_0000;
    ho_time = 32'h0000_0000;
    ho_evt = 32'h0000_0000;
    wt_time = 32'h0000_0000;
    wt_evt = 32'h0000_0000;
    cand = 1'b0;
    fire_pat = 1'b0;
    q = 1'b0;
    val = 1'b0;
    src = 1'b0;
    src_evt = 1'b0;
    hold = 1'b0;
    wload = 32'h0000_0000;
    wcur = 32'h0000_0000;
    ok = 1'b0;
    qual_mode = 1'b0;
    fire_q = 1'b0;
    fire = 1'b0;
    s = r.ctrl.src_sel;
    n = r;

    // comparators are asynchronous to us, two flops before any use
    n.sync1 = cmp_i;
    n.sync2 = r.sync1;

    // bus: answer one cycle after the request, drop ack the cycle after
    // a held request is answered every other cycle, never twice in a row
    acc = wb_req_i.cyc & wb_req_i.stb & ~r.ack;
    wr = acc & wb_req_i.we;
    n.ack = acc;
    n.rdat = 32'h0000_0000;

    // read mux, unmapped addresses read zero
    if (acc) begin
      case (wb_req_i.adr)
        PQT_CTRL_OFS: n.rdat = 32'(r.ctrl);
        PQT_PAT_OFS: n.rdat = 32'(r.pat);
        PQT_HOLDOFF_OFS: n.rdat = r.holdoff;
        PQT_WAIT_OFS: n.rdat = r.waitv;
        PQT_STATUS_OFS: begin
          n.rdat[PQT_ST_REJ_BIT] = r.rej_err;
          n.rdat[PQT_ST_PAT_BIT] = r.pat_prev;
          n.rdat[PQT_ST_HOLD_BIT] = r.armed;
          n.rdat[PQT_ST_IN_LSB +: PQT_NUM_IN] = r.sync2;
        end
        PQT_TRIGCNT_OFS: n.rdat = r.trig_cnt;
        default: begin
          for (int t = 0; t < PQT_NUM_IN; t++) begin
            if (wb_req_i.adr == 8'(PQT_THRESH0_OFS + 8'(4 * t))) begin
              n.rdat = {16'h0000, r.thresh[t]};
            end
          end
        end
      endcase
    end

    // candidate configuration, checked before it is taken
    if (wr && (wb_req_i.adr == PQT_CTRL_OFS)) begin
      wd = lane_merge(32'(r.ctrl), wb_req_i.dat, wb_req_i.sel);
      c_cand = pqt_ctrl_t'(wd[PQT_CTRL_W-1:0]);
      cfg_wr = 1'b1;
    end
    if (wr && (wb_req_i.adr == PQT_PAT_OFS)) begin
      wd = lane_merge(32'(r.pat), wb_req_i.dat, wb_req_i.sel);
      p_cand = wd[2*PQT_NUM_IN-1:0];
      cfg_wr = 1'b1;
    end

    // status: write one clears the refusal flag
    if (wr && (wb_req_i.adr == PQT_STATUS_OFS) && wb_req_i.sel[0] &&
        wb_req_i.dat[PQT_ST_REJ_BIT]) begin
      n.rej_err = 1'b0;
    end
    // a conflicting setup is never stored; refusal wins over a clear
    if (cfg_wr) begin
      if (src_in_pattern(c_cand, p_cand)) begin
        n.rej_err = 1'b1;
      end else begin
        n.ctrl = c_cand;
        n.pat = p_cand;
      end
    end

    // figures are raw clock ticks or event counts, range enforced when used
    if (wr && (wb_req_i.adr == PQT_HOLDOFF_OFS)) begin
      n.holdoff = lane_merge(r.holdoff, wb_req_i.dat, wb_req_i.sel);
    end
    if (wr && (wb_req_i.adr == PQT_WAIT_OFS)) begin
      n.waitv = lane_merge(r.waitv, wb_req_i.dat, wb_req_i.sel);
    end
    for (int t = 0; t < PQT_NUM_IN; t++) begin
      if (wr && (wb_req_i.adr == 8'(PQT_THRESH0_OFS + 8'(4 * t)))) begin
        wd = lane_merge({16'h0000, r.thresh[t]}, wb_req_i.dat, wb_req_i.sel);
        n.thresh[t] = wd[15:0];
      end
    end

    // legal ranges in ticks, or in events for the event figures
    // a figure outside its range is pulled to the nearest end, not refused
    tmin = FAST_VARIANT ? PQT_TMIN_FAST_CYC : PQT_TMIN_CYC;
    ho_time = clamp(r.holdoff, tmin, TMAX_CYC);
    ho_evt = clamp(r.holdoff, PQT_EVT_MIN, PQT_EVT_MAX);
    wt_time = clamp(r.waitv, tmin, TMAX_CYC);
    wt_evt = clamp(r.waitv, PQT_EVT_MIN, PQT_EVT_MAX);

    //////////////////////////////////////////////////////////////////////////
    // pattern mode: edge of the pattern, then hold-off

    // edges come from the synchronised pattern, pulses under a tick are lost
    n.pat_prev = pat_now;
    cand = r.ctrl.slope_exit ? (~pat_now & r.pat_prev) : (pat_now & ~r.pat_prev);
    if (r.ctrl.enable && (r.ctrl.mode == PQT_MODE_PATTERN)) begin
      case (r.ctrl.ho_kind)
        PQT_HO_TIME: begin
          // quiet time after each trigger
          fire_pat = cand && (r.ho_cnt == 32'h0000_0000);
          if (r.ho_cnt != 32'h0000_0000) begin
            n.ho_cnt = r.ho_cnt - 32'h0000_0001;
          end
          if (fire_pat) begin
            n.ho_cnt = ho_time;
          end
        end
        PQT_HO_EVENTS: begin
          // candidates swallowed until the count is used up
          // the first candidate after enable always fires
          fire_pat = cand && (r.ho_cnt == 32'h0000_0000);
          if (cand && (r.ho_cnt != 32'h0000_0000)) begin
            n.ho_cnt = r.ho_cnt - 32'h0000_0001;
          end
          if (fire_pat) begin
            n.ho_cnt = ho_evt - 32'h0000_0001;
          end
        end
        default: begin
          fire_pat = cand;
          n.ho_cnt = 32'h0000_0000;
        end
      endcase
    end else begin
      n.ho_cnt = 32'h0000_0000;
    end

    //////////////////////////////////////////////////////////////////////////
    // qualified modes: the pattern only gates the trigger source

    qual_mode = r.ctrl.enable &&
                ((r.ctrl.mode == PQT_MODE_STATE_QUAL) || (r.ctrl.mode == PQT_MODE_EDGE_QUAL));
    q = pat_now ^ r.ctrl.qual_absent;
    n.q_prev = q;
    val = q & ~r.q_prev;
    // an out-of-range source reads as a quiet low input
    if (s < 3'(PQT_NUM_IN)) begin
      src = r.sync2[s];
    end
    n.src_prev = src;
    src_evt = r.ctrl.src_fall ? (~src & r.src_prev) : (src & ~r.src_prev);

    // state mode needs the qualifier now; edge mode only needs the arming
    if (r.ctrl.mode == PQT_MODE_STATE_QUAL) begin
      hold = q;
    end else begin
      hold = r.armed | val;
    end

    // every validation reloads the wait
    wload = (r.ctrl.wait_kind == PQT_WT_EVENTS) ? wt_evt : wt_time;
    wcur = val ? wload : r.wcnt;
    case (r.ctrl.wait_kind)
      PQT_WT_TIME: ok = (wcur == 32'h0000_0000);
      PQT_WT_WINDOW: ok = (wcur != 32'h0000_0000);
      PQT_WT_EVENTS: ok = (wcur <= 32'h0000_0001);
      default: ok = 1'b1;
    endcase

    // timer runs only while held; counter steps on source events only
    n.wcnt = wcur;
    if (hold) begin
      if (r.ctrl.wait_kind == PQT_WT_EVENTS) begin
        if (src_evt && (wcur > 32'h0000_0001)) begin
          n.wcnt = wcur - 32'h0000_0001;
        end
      end else if (wcur != 32'h0000_0000) begin
        n.wcnt = wcur - 32'h0000_0001;
      end
    end

    // outside the qualified modes the wait sits at its reload value,
    // so a later enable never starts from a stale count
    if (!qual_mode) begin
      n.wcnt = wload;
    end

    // refusal check repeated in case a stored setup is ever bypassed
    fire_q = qual_mode && src_evt && hold && ok &&
             !src_in_pattern(r.ctrl, r.pat);

    // edge mode needs a fresh validation after each trigger
    // a validation in the firing cycle arms again at once
    if (qual_mode && (r.ctrl.mode == PQT_MODE_EDGE_QUAL)) begin
      n.armed = val | (r.armed & ~fire_q);
    end else if (qual_mode) begin
      n.armed = q;
    end else begin
      n.armed = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // trigger output and its counter

    // only one path is live at a time, the mode decides which
    fire = fire_pat | fire_q;
    n.trig = fire;
    if (fire) begin
      n.trig_cnt = r.trig_cnt + 32'h0000_0001;
    end
    if (wr && (wb_req_i.adr == PQT_TRIGCNT_OFS)) begin
      // any write clears the count, a trigger in that cycle is still kept
      n.trig_cnt = fire ? 32'h0000_0001 : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // all zero first, then the nonzero defaults on top
      r <= '0;
      r.ctrl <= PQT_CTRL_RST;
      r.holdoff <= PQT_HOLDOFF_RST;
      r.waitv <= PQT_WAIT_RST;
      r.thresh <= {PQT_NUM_IN{PQT_THRESH_RST}};
    end else begin
      r <= n;
    end
  end

  // outputs straight from flops
  assign wb_rsp_o.ack = r.ack;
  assign wb_rsp_o.dat = r.rdat;
  assign thresh_level_o = r.thresh;
  assign trig_o = r.trig;

endmodule : pqt_trigger

/* test/pqt_cmp_model.sv */
`timescale 1ns/1ps
// comparator bank in front of the trigger block
module pqt_cmp_model
  import pqt_pkg::*;
(
  // thresholds from the block, analog levels from the bench
  input wire pqt_pkg::pqt_thresh_t thresh_i,
  input wire pqt_pkg::pqt_thresh_t level_i,
  // comparator outputs
  output logic [pqt_pkg::PQT_NUM_IN-1:0] cmp_o
);
  // strictly above is high, equal reads low
  always_comb begin
    for (int i = 0; i < PQT_NUM_IN; i++) begin
      cmp_o[i] = level_i[i] > thresh_i[i];
    end
  end
endmodule : pqt_cmp_model

/* test/pqt_trigger_asserts.sv */
`timescale 1ns/1ps
module pqt_trigger_asserts
  import pqt_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched ports
  input wire pqt_pkg::pqt_wb_req_t wb_req_i,
  input wire pqt_pkg::pqt_wb_rsp_t wb_rsp_o,
  input wire logic [pqt_pkg::PQT_NUM_IN-1:0] cmp_i,
  input wire pqt_pkg::pqt_thresh_t thresh_level_o,
  input wire logic trig_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // bus answer lasts one cycle and only follows a taken request
  a_ack_single: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack longer than one cycle");
  a_ack_taken: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
    else $error("request not answered");
  a_ack_cause: assert property (wb_rsp_o.ack |-> $past(wb_req_i.cyc && wb_req_i.stb))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0000_0000)
    else $error("read data outside ack");
  ////////////////////////////////////////////////////////////////////////////
  // thresholds move only by reset or an answered write
  a_thr_reset: assert property ($past(rst_i) |-> thresh_level_o == {PQT_NUM_IN{PQT_THRESH_RST}})
    else $error("threshold not at reset value");
  a_thr_write: assert property ($changed(thresh_level_o) |-> wb_rsp_o.ack && $past(wb_req_i.we))
    else $error("threshold moved without write");
  // trigger is a pulse from an input edge three cycles earlier
  a_trig_pulse: assert property (trig_o |=> !trig_o)
    else $error("trigger longer than one cycle");
  a_trig_cause: assert property (trig_o |-> $past(cmp_i, 3) != $past(cmp_i, 4))
    else $error("trigger without input edge");
  a_trig_reset: assert property ($past(rst_i) |-> !trig_o && !wb_rsp_o.ack)
    else $error("output active after reset");
endmodule : pqt_trigger_asserts
bind pqt_trigger pqt_trigger_asserts u_asserts (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_req_i(wb_req_i),
  .wb_rsp_o(wb_rsp_o),
  .cmp_i(cmp_i),
  .thresh_level_o(thresh_level_o),
  .trig_o(trig_o)
);

/* test/pqt_trigger_tb_top.sv */
`timescale 1ns/1ps
module pqt_trigger_tb_top;
  import pqt_pkg::*;
  logic clk_i;
  logic rst_i;
  pqt_wb_req_t req;
  pqt_wb_rsp_t rsp;
  logic [PQT_NUM_IN-1:0] cmp;
  pqt_thresh_t thr;
  pqt_thresh_t lvl;
  pqt_thresh_t th;
  pqt_ctrl_t c;
  logic trig;
  logic [31:0] q;
  logic [31:0] n_trig;
  int n_fail;
  int tests_run;
  // qualified cases: two bits a step, qualifier input 1 over source input 0
  pqt_mode_t qm [5] = '{PQT_MODE_STATE_QUAL, PQT_MODE_STATE_QUAL, PQT_MODE_STATE_QUAL,
    PQT_MODE_EDGE_QUAL, PQT_MODE_STATE_QUAL};
  pqt_wait_t qw [5] = '{PQT_WT_TIME, PQT_WT_WINDOW, PQT_WT_EVENTS, PQT_WT_NONE, PQT_WT_NONE};
  logic [31:0] qs [5] = '{32'h02ee_e12e, 32'h02ee_e12e, 32'h02ee_e12e, 32'h0000_0844,
    32'h0000_212e};
  int ql [5] = '{14, 14, 14, 8, 8};
  logic [31:0] qe [5] = '{32'h0000_0001, 32'h0000_0003, 32'h0000_0002, 32'h0000_0001,
    32'h0000_0001};

  // small max count keeps clamping visible in a short run
  pqt_trigger #(.FAST_VARIANT(1'b0), .TMAX_CYC(32'h0000_0040)) dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_req_i(req),
    .wb_rsp_o(rsp),
    .cmp_i(cmp),
    .thresh_level_o(thr),
    .trig_o(trig)
  );
  pqt_cmp_model u_cmp (.thresh_i(thr), .level_i(lvl), .cmp_o(cmp));

  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // count every trigger pulse seen
  always @(posedge clk_i) begin
    if (trig === 1'b1) n_trig <= n_trig + 32'h0000_0001;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  // one classic cycle, held until ack is sampled
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, we, a, 4'hf, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 20);
    q = rsp.dat;
    req <= '0;
    if (n >= 20) begin
      check("bus answer", 32'h0000_0000, 32'h0000_0001);
      final_report();
    end
  endtask : bus
  // analog levels a margin either side of each threshold, then 8 cycles
  task automatic set_in(input logic [4:0] b);
    @(posedge clk_i);
    for (int i = 0; i < PQT_NUM_IN; i++) begin
      lvl[i] <= b[i] ? th[i] + 16'h0100 : th[i] - 16'h0100;
    end
    repeat (8) @(posedge clk_i);
  endtask : set_in
  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    th = {PQT_NUM_IN{PQT_THRESH_RST}};
  endtask : do_reset
  // reference pattern: and of required terms
  function automatic logic patf(input logic [9:0] p, input logic [4:0] b);
    patf = 1'b1;
    for (int i = 0; i < 5; i++) begin
      if (p[2*i+:2] == PQT_TERM_HIGH && !b[i]) patf = 1'b0;
      if (p[2*i+:2] == PQT_TERM_LOW && b[i]) patf = 1'b0;
    end
  endfunction : patf
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [9:0] p;
    logic [4:0] b;
    logic pm;
    logic pn;
    int gap;
    int since;
    logic [31:0] ne;
    rst_i = 1'b1;
    req = '0;
    lvl = '0;
    th = '0;
    n_trig = '0;
    n_fail = 0;
    tests_run = 0;
    void'($urandom(32'h7b51d16f));
    do_reset();
    // reset values, unmapped place ignored
    bus(1'b1, 8'h40, 32'hffff_ffff);
    bus(1'b0, 8'h40, 32'h0000_0000);
    check("unmapped", q, 32'h0000_0000);
    bus(1'b0, PQT_HOLDOFF_OFS, 32'h0000_0000);
    check("holdoff reset", q, PQT_HOLDOFF_RST);
    // thresholds set one by one
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, PQT_THRESH0_OFS + 8'(4 * i), 32'h0000_0000);
      check("thresh reset", q, 32'h0000_8000);
      th[i] = 16'h1000 + 16'($urandom_range(16'hdfff));
      bus(1'b1, PQT_THRESH0_OFS + 8'(4 * i), {16'h0000, th[i]});
      bus(1'b0, PQT_THRESH0_OFS + 8'(4 * i), 32'h0000_0000);
      check("thresh", q, {16'h0000, th[i]});
    end
    for (int i = 0; i < 5; i++) check("thresh out", 32'(thr[i]), 32'(th[i]));
    // pattern mode: both slopes, no, time and event hold-off
    for (int k = 0; k < 6; k++) begin
      do_reset();
      p = 10'($urandom());
      p[2*(k%5)+:2] = PQT_TERM_HIGH;
      for (int i = 0; i < 5; i++) b[i] = (p[2*i+:2] == PQT_TERM_LOW);
      set_in(b);
      c = '0;
      c.enable = 1'b1;
      c.slope_exit = k[0];
      c.ho_kind = pqt_ho_t'(k / 2);
      bus(1'b1, PQT_PAT_OFS, {22'h00_0000, p});
      bus(1'b1, PQT_HOLDOFF_OFS, (k / 2 == 1) ? 32'h0000_0018 : 32'h0000_0003);
      bus(1'b1, PQT_CTRL_OFS, 32'(c));
      pm = patf(p, b);
      gap = 2;
      since = 1000;
      ne = n_trig;
      for (int s = 0; s < 16; s++) begin
        b = 5'($urandom());
        set_in(b);
        since += 9;
        pn = patf(p, b);
        if (pn != pm && pn != c.slope_exit) begin
          gap++;
          if (k / 2 == 0 || (k / 2 == 1 && since >= 24) || (k / 2 == 2 && gap >= 3)) begin
            ne++;
            gap = 0;
            since = 0;
          end
        end
        pm = pn;
        check("pattern triggers", n_trig, ne);
      end
    end
    // qualified modes, counter read back then cleared
    for (int j = 0; j < 5; j++) begin
      do_reset();
      set_in(5'h00);
      c = '0;
      c.enable = 1'b1;
      c.mode = qm[j];
      c.wait_kind = qw[j];
      c.qual_absent = (j == 4);
      c.src_fall = (j == 3);
      bus(1'b1, PQT_WAIT_OFS, (qw[j] == PQT_WT_EVENTS) ? 32'h0000_0002 : 32'h0000_001e);
      bus(1'b1, PQT_PAT_OFS, 32'h0000_0004);
      bus(1'b1, PQT_CTRL_OFS, 32'(c));
      ne = n_trig;
      for (int s = ql[j] - 1; s >= 0; s--) set_in({3'h0, qs[j][2*s+:2]});
      check("qualified triggers", n_trig - ne, qe[j]);
      bus(1'b0, PQT_TRIGCNT_OFS, 32'h0000_0000);
      check("trigger counter", q, qe[j]);
      bus(1'b1, PQT_TRIGCNT_OFS, 32'h0000_0000);
      bus(1'b0, PQT_TRIGCNT_OFS, 32'h0000_0000);
      check("counter cleared", q, 32'h0000_0000);
    end
    // source inside the pattern or out of range is refused
    do_reset();
    bus(1'b1, PQT_PAT_OFS, 32'h0000_0001);
    c = '0;
    c.enable = 1'b1;
    c.mode = PQT_MODE_STATE_QUAL;
    bus(1'b1, PQT_CTRL_OFS, 32'(c));
    bus(1'b0, PQT_CTRL_OFS, 32'h0000_0000);
    check("ctrl refused", q, 32'h0000_0000);
    bus(1'b0, PQT_STATUS_OFS, 32'h0000_0000);
    check("refused flag", 32'(q[0]), 32'h0000_0001);
    bus(1'b1, PQT_STATUS_OFS, 32'h0000_0001);
    bus(1'b0, PQT_STATUS_OFS, 32'h0000_0000);
    check("flag cleared", 32'(q[0]), 32'h0000_0000);
    bus(1'b1, PQT_PAT_OFS, 32'h0000_0004);
    bus(1'b1, PQT_CTRL_OFS, 32'(c));
    bus(1'b1, PQT_PAT_OFS, 32'h0000_0001);
    bus(1'b0, PQT_PAT_OFS, 32'h0000_0000);
    check("pattern refused", q, 32'h0000_0004);
    c.src_sel = 3'h5;
    bus(1'b1, PQT_CTRL_OFS, 32'(c));
    bus(1'b0, PQT_CTRL_OFS, 32'h0000_0000);
    c.src_sel = 3'h0;
    check("source range refused", q, 32'(c));
    final_report();
  end
endmodule : pqt_trigger_tb_top
